// *** rx_los_consts.vh ***
`ifndef RX_LOS_CONSTS_VH
`define RX_LOS_CONSTS_VH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_CFG_A       8'h04
`define OFS_CFG_B       8'h08
`define OFS_POWERDOWN   8'h0C
`define OFS_LOS_LIVE    8'h10
`define OFS_INT_STATUS  8'h14
`define OFS_INT_MASK    8'h18

// control register fields
`define CTRL_E1_BIT      0
`define CTRL_AUX_EN_BIT  1
`define CTRL_AUX_FAST    2
`define CTRL_W           3
`define CTRL_RESET       3'h0

// rx_config_reg_a fields
`define CFGA_HIGHZ_BIT   6
`define CFGA_HOLD_BIT    7
// rx_config_reg_b fields
`define CFGB_FMT_LO      0
`define CFGB_FMT_HI      1
`define CFGB_EDGE_BIT    4
`define CFG_W            8
`define CFG_RESET        8'h00

// receive system interface formats
`define FMT_SINGLE_NRZ   2'h0
`define FMT_DUAL_NRZ     2'h1
`define FMT_DUAL_RZ      2'h2
`define FMT_DUAL_SLICED  2'h3

// serial status sequence
`define CHANNELS         17
`define SLOT_W           5
`define SLOT_FIRST       5'h00
`define SLOT_LAST        5'h10

// clock synthesis, phase accumulator of 32 bits from hclk
`define HCLK_HZ          64'd50000000
`define RATE_T1_HZ       64'd1544000
`define RATE_E1_HZ       64'd2048000
`define AUX_SLOW_HZ      64'd8000
`define AUX_FAST_HZ      64'd2048000
`define ACC_SPAN         64'h0000_0001_0000_0000
`define INC_OF(f)        (((f) * `ACC_SPAN) / `HCLK_HZ)

`endif

// *** clock_synth.v ***
`timescale 1ns/1ps
`default_nettype none

// fractional divider: msb of a phase accumulator, jitter one hclk period
module clock_synth #(
	parameter ACC_W = 32
) (
	// clock and reset
	input  wire             hclk,
	input  wire             hresetn,
	input  wire             ce,
	// control
	input  wire             enable,
	input  wire [ACC_W-1:0] increment,
	// generated clock
	output reg              clk_q,
	output reg              rise_q
);

	reg  [ACC_W-1:0] acc_q;
	wire [ACC_W-1:0] acc_d;

	assign acc_d = acc_q + increment;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_q  <= {ACC_W{1'b0}};
			clk_q  <= 1'b0;
			rise_q <= 1'b0;
		end else if (ce) begin
			if (!enable) begin
				// restart from phase zero so the first edge is clean
				acc_q  <= {ACC_W{1'b0}};
				clk_q  <= 1'b0;
				rise_q <= 1'b0;
			end else begin
				acc_q  <= acc_d;
				clk_q  <= acc_d[ACC_W-1];
				rise_q <= acc_d[ACC_W-1] & ~clk_q;
			end
		end
	end

endmodule

`default_nettype wire

// *** rx_clock_los.v ***
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rx_los_consts.vh"

module rx_clock_los #(
	parameter NCH = `CHANNELS
) (
	// clock, reset, enable
	input  wire            hclk,
	input  wire            hresetn,
	input  wire            ce,
	// ahb-lite slave
	input  wire            hsel,
	input  wire [31:0]     haddr,
	input  wire [1:0]      htrans,
	input  wire            hwrite,
	input  wire [2:0]      hsize,
	input  wire [31:0]     hwdata,
	input  wire            hready,
	output reg  [31:0]     hrdata,
	output reg             hreadyout,
	output reg             hresp,
	// from the clock and data recovery and the los detectors
	input  wire [NCH-1:0]  cdr_clock_in,
	input  wire [NCH-1:0]  cdr_data_pos_in,
	input  wire [NCH-1:0]  cdr_data_neg_in,
	input  wire [NCH-1:0]  multifunction_in,
	input  wire [NCH-1:0]  line_los_in,
	// receive system interface
	output reg  [NCH-1:0]  recovered_clock_out,
	output reg  [NCH-1:0]  recovered_clock_oe,
	output reg  [NCH-1:0]  rx_data_positive_rail,
	output reg  [NCH-1:0]  rx_data_negative_rail,
	// serial loss of signal
	output reg             aux_clock_out,
	output reg             line_signal_loss_serial,
	output reg             line_signal_loss_serial_oe,
	output reg             channel_zero_marker,
	output reg             channel_zero_marker_oe,
	// interrupt
	output reg             irq
);

	localparam [63:0] INC_T1   = `INC_OF(`RATE_T1_HZ);
	localparam [63:0] INC_E1   = `INC_OF(`RATE_E1_HZ);
	localparam [63:0] INC_SLOW = `INC_OF(`AUX_SLOW_HZ);
	localparam [63:0] INC_FAST = `INC_OF(`AUX_FAST_HZ);

	// serial slot states, one-hot
	localparam [1:0] ST_OFF = 2'b01;
	localparam [1:0] ST_RUN = 2'b10;

	function sel_hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			sel_hit = (addr == ofs);
		end
	endfunction

	// ---------------- register file ----------------
	reg [`CTRL_W-1:0] ctrl_q;
	reg [`CFG_W-1:0]  cfg_a_q;
	reg [`CFG_W-1:0]  cfg_b_q;
	reg [NCH-1:0]     pwrdn_q;
	reg [NCH-1:0]     int_status_q;
	reg [NCH-1:0]     int_mask_q;

	reg               wr_pend_q;
	reg [7:0]         wr_addr_q;
	reg [31:0]        rd_d;
	wire              addr_phase;
	wire              wr_now;
	wire [NCH-1:0]    wdat;

	wire              e1_mode;
	wire              aux_en;
	wire              aux_fast;
	wire              clk_hold;
	wire              pd_highz;
	wire              edge_fall;
	wire [1:0]        fmt;
	wire              sliced;

	assign addr_phase = hsel & hready & htrans[1];
	assign wr_now     = wr_pend_q;
	assign wdat       = hwdata[NCH-1:0];

	assign e1_mode    = ctrl_q[`CTRL_E1_BIT];
	assign aux_en     = ctrl_q[`CTRL_AUX_EN_BIT];
	assign aux_fast   = ctrl_q[`CTRL_AUX_FAST];
	assign clk_hold   = cfg_a_q[`CFGA_HOLD_BIT];
	assign pd_highz   = cfg_a_q[`CFGA_HIGHZ_BIT];
	assign edge_fall  = cfg_b_q[`CFGB_EDGE_BIT];
	assign fmt        = cfg_b_q[`CFGB_FMT_HI:`CFGB_FMT_LO];
	assign sliced     = (fmt == `FMT_DUAL_SLICED);

	// ---------------- input synchronisers ----------------
	reg [NCH-1:0] rc_s1;
	reg [NCH-1:0] rc_s2;
	reg [NCH-1:0] rc_s3;
	reg [NCH-1:0] dp_s1;
	reg [NCH-1:0] dp_s2;
	reg [NCH-1:0] dn_s1;
	reg [NCH-1:0] dn_s2;
	reg [NCH-1:0] mf_s1;
	reg [NCH-1:0] mf_s2;
	reg [NCH-1:0] los_s1;
	reg [NCH-1:0] los_s2;
	reg [NCH-1:0] los_s3;
	wire [NCH-1:0] los_onset;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rc_s1  <= {NCH{1'b0}};
			rc_s2  <= {NCH{1'b0}};
			rc_s3  <= {NCH{1'b0}};
			dp_s1  <= {NCH{1'b0}};
			dp_s2  <= {NCH{1'b0}};
			dn_s1  <= {NCH{1'b0}};
			dn_s2  <= {NCH{1'b0}};
			mf_s1  <= {NCH{1'b0}};
			mf_s2  <= {NCH{1'b0}};
			los_s1 <= {NCH{1'b0}};
			los_s2 <= {NCH{1'b0}};
			los_s3 <= {NCH{1'b0}};
		end else if (ce) begin
			rc_s1  <= cdr_clock_in;
			rc_s2  <= rc_s1;
			rc_s3  <= rc_s2;
			dp_s1  <= cdr_data_pos_in;
			dp_s2  <= dp_s1;
			dn_s1  <= cdr_data_neg_in;
			dn_s2  <= dn_s1;
			mf_s1  <= multifunction_in;
			mf_s2  <= mf_s1;
			los_s1 <= line_los_in;
			los_s2 <= los_s1;
			los_s3 <= los_s2;
		end
	end

	assign los_onset = los_s2 & ~los_s3;

	// ---------------- bus slave ----------------
	always @* begin
		rd_d = 32'h0000_0000;
		if (sel_hit(haddr[7:0], `OFS_CTRL))
			rd_d[`CTRL_W-1:0] = ctrl_q;
		else if (sel_hit(haddr[7:0], `OFS_CFG_A))
			rd_d[`CFG_W-1:0] = cfg_a_q;
		else if (sel_hit(haddr[7:0], `OFS_CFG_B))
			rd_d[`CFG_W-1:0] = cfg_b_q;
		else if (sel_hit(haddr[7:0], `OFS_POWERDOWN))
			rd_d[NCH-1:0] = pwrdn_q;
		else if (sel_hit(haddr[7:0], `OFS_LOS_LIVE))
			rd_d[NCH-1:0] = los_s2;
		else if (sel_hit(haddr[7:0], `OFS_INT_STATUS))
			rd_d[NCH-1:0] = int_status_q;
		else if (sel_hit(haddr[7:0], `OFS_INT_MASK))
			rd_d[NCH-1:0] = int_mask_q;
	end

	// zero wait states: read data is fetched in the address phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else if (ce) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend_q <= addr_phase & hwrite;
			if (addr_phase) begin
				wr_addr_q <= haddr[7:0];
				hrdata    <= hwrite ? 32'h0000_0000 : rd_d;
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q     <= `CTRL_RESET;
			cfg_a_q    <= `CFG_RESET;
			cfg_b_q    <= `CFG_RESET;
			pwrdn_q    <= {NCH{1'b0}};
			int_mask_q <= {NCH{1'b0}};
		end else if (ce && wr_now) begin
			if (sel_hit(wr_addr_q, `OFS_CTRL))
				ctrl_q <= hwdata[`CTRL_W-1:0];
			if (sel_hit(wr_addr_q, `OFS_CFG_A))
				cfg_a_q <= hwdata[`CFG_W-1:0];
			if (sel_hit(wr_addr_q, `OFS_CFG_B))
				cfg_b_q <= hwdata[`CFG_W-1:0];
			if (sel_hit(wr_addr_q, `OFS_POWERDOWN))
				pwrdn_q <= wdat;
			if (sel_hit(wr_addr_q, `OFS_INT_MASK))
				int_mask_q <= wdat;
		end
	end

	// sticky los onset; a new onset beats a write-one clear
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_status_q <= {NCH{1'b0}};
			irq          <= 1'b0;
		end else if (ce) begin
			if (wr_now && sel_hit(wr_addr_q, `OFS_INT_STATUS))
				int_status_q <= (int_status_q & ~wdat) | los_onset;
			else
				int_status_q <= int_status_q | los_onset;
			irq <= |(int_status_q & int_mask_q);
		end
	end

	// ---------------- clock synthesis ----------------
	wire ref_clk;
	wire aux_clk;
	wire aux_rise;

	clock_synth #(
		.ACC_W     (32)
	) u_ref_synth (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.enable    (1'b1),
		.increment (e1_mode ? INC_E1[31:0] : INC_T1[31:0]),
		.clk_q     (ref_clk),
		.rise_q    ()
	);

	clock_synth #(
		.ACC_W     (32)
	) u_aux_synth (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.enable    (aux_en),
		.increment (aux_fast ? INC_FAST[31:0] : INC_SLOW[31:0]),
		.clk_q     (aux_clk),
		.rise_q    (aux_rise)
	);

	// ---------------- per channel receive outputs ----------------
	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
			wire act_edge;
			assign act_edge = edge_fall ? (rc_s3[ch] & ~rc_s2[ch])
			                            : (rc_s2[ch] & ~rc_s3[ch]);

			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					recovered_clock_out[ch]   <= 1'b0;
					recovered_clock_oe[ch]    <= 1'b0;
					rx_data_positive_rail[ch] <= 1'b0;
					rx_data_negative_rail[ch] <= 1'b0;
				end else if (ce) begin
					if (pwrdn_q[ch]) begin
						recovered_clock_out[ch]   <= 1'b0;
						recovered_clock_oe[ch]    <= ~pd_highz;
						rx_data_positive_rail[ch] <= 1'b0;
						rx_data_negative_rail[ch] <= 1'b0;
					end else begin
						recovered_clock_oe[ch] <= 1'b1;
						if (sliced) begin
							recovered_clock_out[ch] <= mf_s2[ch];
						end else if (los_s2[ch]) begin
							recovered_clock_out[ch] <= clk_hold | ref_clk;
						end else begin
							recovered_clock_out[ch] <= rc_s2[ch];
						end
						// sliced data is raw, not clocked out
						if (sliced) begin
							rx_data_positive_rail[ch] <= dp_s2[ch];
							rx_data_negative_rail[ch] <= dn_s2[ch];
						end else if (act_edge) begin
							rx_data_positive_rail[ch] <= dp_s2[ch];
							rx_data_negative_rail[ch] <= (fmt == `FMT_SINGLE_NRZ)
							                             ? mf_s2[ch] : dn_s2[ch];
						end
					end
				end
			end
		end
	endgenerate

	// ---------------- serial loss of signal ----------------
	reg [1:0]          state_q;
	reg [`SLOT_W-1:0]  slot_q;
	reg [`SLOT_W-1:0]  slot_d;

	always @* begin
		slot_d = slot_q + 5'h01;
		if (slot_q == `SLOT_LAST)
			slot_d = `SLOT_FIRST;
	end

	// slot counter parks on the last slot so the first shown is channel 0
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q                    <= ST_OFF;
			slot_q                     <= `SLOT_LAST;
			aux_clock_out              <= 1'b0;
			line_signal_loss_serial    <= 1'b0;
			line_signal_loss_serial_oe <= 1'b0;
			channel_zero_marker        <= 1'b0;
			channel_zero_marker_oe     <= 1'b0;
		end else if (ce) begin
			aux_clock_out <= aux_clk;
			case (state_q)
				ST_OFF: begin
					slot_q                     <= `SLOT_LAST;
					line_signal_loss_serial    <= 1'b0;
					line_signal_loss_serial_oe <= 1'b0;
					channel_zero_marker        <= 1'b0;
					channel_zero_marker_oe     <= 1'b0;
					if (aux_en)
						state_q <= ST_RUN;
				end
				ST_RUN: begin
					line_signal_loss_serial_oe <= 1'b1;
					channel_zero_marker_oe     <= 1'b1;
					if (!aux_en) begin
						state_q <= ST_OFF;
					end else if (aux_rise) begin
						// updated with the pin's rising edge, high = lost
						slot_q                  <= slot_d;
						line_signal_loss_serial <= los_s2[slot_d];
						channel_zero_marker <= (slot_d == `SLOT_FIRST);
					end
				end
				default: begin
					state_q <= ST_OFF;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// *** rx_los_chk_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module rx_los_chk #(
	parameter NCH = 17
) (
	// clock and reset
	input wire logic           hclk,
	input wire logic           hresetn,
	// pins
	input wire logic [NCH-1:0] recovered_clock_out,
	input wire logic [NCH-1:0] recovered_clock_oe,
	input wire logic           aux_clock_out,
	input wire logic           line_signal_loss_serial,
	input wire logic           line_signal_loss_serial_oe,
	input wire logic           channel_zero_marker,
	input wire logic           channel_zero_marker_oe
);
	logic       aux_q;
	logic [4:0] gap_q;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// sees each aux rise one hclk late, same as the sampled values do
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aux_q <= 1'b0;
			gap_q <= 5'h00;
		end else begin
			aux_q <= aux_clock_out;
			if (!channel_zero_marker_oe)
				gap_q <= 5'h00;
			else if (aux_clock_out && !aux_q)
				gap_q <= channel_zero_marker ? 5'h01 : gap_q + 5'h01;
		end
	end
	sequence aux_rise_s;
		$rose(aux_clock_out);
	endsequence
	sequence mark_rise_s;
		$rose(channel_zero_marker);
	endsequence
	serial_edge_a:
		assert property ($changed(line_signal_loss_serial) &&
			line_signal_loss_serial_oe && $past(line_signal_loss_serial_oe)
			|-> aux_rise_s) else $error("serial bit moved off aux rise");
	marker_edge_a:
		assert property ($changed(channel_zero_marker) &&
			channel_zero_marker_oe && $past(channel_zero_marker_oe)
			|-> aux_rise_s) else $error("marker moved off aux rise");
	marker_once_a:
		assert property (aux_rise_s |->
			!(channel_zero_marker && $past(channel_zero_marker)))
			else $error("marker longer than one aux cycle");
	marker_gap_a:
		assert property (mark_rise_s ##0 (gap_q != 5'h00) |->
			gap_q == 5'h11) else $error("marker period not 17 slots");
	first_slot_a:
		assert property (aux_rise_s ##0 (channel_zero_marker_oe &&
			gap_q == 5'h00) |-> channel_zero_marker)
			else $error("first slot is not channel 0");
	serial_off_a:
		assert property (!line_signal_loss_serial_oe |->
			!line_signal_loss_serial) else $error("serial driven when off");
	marker_off_a:
		assert property (!channel_zero_marker_oe |-> !channel_zero_marker)
			else $error("marker driven when off");
	oe_pair_a:
		assert property (line_signal_loss_serial_oe ==
			channel_zero_marker_oe) else $error("serial and marker oe differ");
	pin_low_a:
		assert property ((recovered_clock_out & ~recovered_clock_oe) == '0)
			else $error("undriven clock pin not low");
endmodule
bind rx_clock_los rx_los_chk #(.NCH(NCH)) chk (
	.hclk(hclk),
	.hresetn(hresetn),
	.recovered_clock_out(recovered_clock_out),
	.recovered_clock_oe(recovered_clock_oe),
	.aux_clock_out(aux_clock_out),
	.line_signal_loss_serial(line_signal_loss_serial),
	.line_signal_loss_serial_oe(line_signal_loss_serial_oe),
	.channel_zero_marker(channel_zero_marker),
	.channel_zero_marker_oe(channel_zero_marker_oe)
);
`default_nettype wire

// *** los_framer.sv ***
`timescale 1ns/1ps
`default_nettype none
module los_framer #(
	parameter NCH = 17
) (
	// clock and reset
	input wire logic            hclk,
	input wire logic            hresetn,
	// serial status link
	input wire logic            aux_clock_out,
	input wire logic            line_signal_loss_serial,
	input wire logic            channel_zero_marker,
	// captured frame
	output logic [NCH-1:0]      frame_q,
	output logic [7:0]          frames_q,
	output logic [15:0]         gap_q
);
	logic           aux_q;
	logic [4:0]     slot_q;
	logic [15:0]    run_q;
	logic [NCH-1:0] acc_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aux_q <= 1'b0;
			slot_q <= 5'(NCH);
			run_q <= 16'h0000;
			acc_q <= '0;
			frame_q <= '0;
			frames_q <= 8'h00;
			gap_q <= 16'h0000;
		end else begin
			aux_q <= aux_clock_out;
			run_q <= run_q + 16'h0001;
			if (aux_clock_out && !aux_q) begin
				if (channel_zero_marker) begin
					slot_q <= 5'h01;
					acc_q[0] <= line_signal_loss_serial;
					gap_q <= run_q;
					run_q <= 16'h0001;
				end else if (slot_q < 5'(NCH)) begin
					slot_q <= slot_q + 5'h01;
					acc_q[slot_q] <= line_signal_loss_serial;
					// frame closes on the last channel only
					if (slot_q == 5'(NCH - 1)) begin
						frame_q <= {line_signal_loss_serial, acc_q[NCH-2:0]};
						frames_q <= frames_q + 8'h01;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** rx_clock_los_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rx_los_consts.vh"
module rx_clock_los_bench;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [16:0] cdr_clk = 17'h0_0000;
	logic [16:0] cdr_pos = 17'h0_0000;
	logic [16:0] mf_in = 17'h0_0000;
	logic [16:0] los_in = 17'h0_0000;
	logic [31:0] hrdata, rd;
	logic [16:0] rco, rcoe, rdp, rx_data_single_rail, frame;
	logic        hready, hresp, aux, los_s, los_oe, mk, mk_oe, irq;
	logic        ce = 1'b1;
	logic [7:0]  frames;
	logic [15:0] gap;
	int          failures = 0;
	int          compares = 0;
	rx_clock_los dut (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .cdr_clock_in(cdr_clk),
		.cdr_data_pos_in(cdr_pos), .cdr_data_neg_in(~cdr_pos),
		.multifunction_in(mf_in), .line_los_in(los_in),
		.recovered_clock_out(rco), .recovered_clock_oe(rcoe),
		.rx_data_positive_rail(rdp), .rx_data_negative_rail(rx_data_single_rail),
		.aux_clock_out(aux), .line_signal_loss_serial(los_s),
		.line_signal_loss_serial_oe(los_oe), .channel_zero_marker(mk),
		.channel_zero_marker_oe(mk_oe), .irq(irq));
	los_framer #(.NCH(17)) fr (
		.hclk(hclk), .hresetn(hresetn), .aux_clock_out(aux),
		.line_signal_loss_serial(los_s), .channel_zero_marker(mk),
		.frame_q(frame), .frames_q(frames), .gap_q(gap));
	always #10 hclk = ~hclk;
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic final_report();
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic t_reset();
		bus(1'b0, 8'h1C, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		chk("hresp", 32'h0, hresp);
		chk("serial oe", 32'h0, los_oe);
		chk("marker oe", 32'h0, mk_oe);
	endtask
	task automatic t_serial();
		los_in <= 17'h1_2A5C;
		tick(4);
		wr(`OFS_CTRL, 32'h0000_0006);
		for (int i = 0; i < 3000 && frames < 8'h02; i++) tick(1);
		chk("frames", 32'h2, frames);
		chk("frame", 32'h1_2A5C, frame);
		// aux period is fractional, one hclk of jitter either way
		chk("gap", 415, (gap > 413 && gap < 417) ? 415 : gap);
		wr(`OFS_CTRL, 32'h0);
		tick(4);
		chk("serial oe", 32'h0, los_oe);
		chk("marker oe", 32'h0, mk_oe);
	endtask
	task automatic t_slow();
		int n;
		n = 0;
		wr(`OFS_CTRL, 32'h0000_0002);
		while (mk !== 1'b1 && n < 14000) begin
			tick(1);
			n++;
		end
		n = 0;
		while (mk === 1'b1 && n < 7000) begin
			tick(1);
			n++;
		end
		chk("width", 6250, (n > 6248 && n < 6252) ? 6250 : n);
		wr(`OFS_CTRL, 32'h0);
	endtask
	task automatic t_pin();
		int n;
		int k;
		logic p;
		// line los left over from the serial test would swap in the reference
		los_in <= 17'h0_0000;
		wr(`OFS_CFG_B, 32'h0000_0001);
		cdr_clk <= 17'h0_F0F0;
		tick(5);
		chk("rclk", 32'h0_F0F0, rco);
		wr(`OFS_CFG_B, 32'h0000_0003);
		mf_in <= 17'h1_0F0F;
		tick(5);
		chk("mf pin", 32'h1_0F0F, rco);
		wr(`OFS_CFG_B, 32'h0);
		wr(`OFS_CFG_A, 32'h0000_0080);
		los_in <= 17'h1_FFFF;
		tick(5);
		chk("los hold", 32'h1_FFFF, rco);
		bus(1'b0, `OFS_LOS_LIVE, 32'h0, rd);
		chk("live los", 32'h1_FFFF, rd);
		wr(`OFS_INT_MASK, 32'h0);
		tick(2);
		chk("irq masked", 32'h0, irq);
		wr(`OFS_INT_MASK, 32'h0000_0008);
		tick(2);
		chk("irq", 32'h1, irq);
		wr(`OFS_INT_STATUS, 32'h0001_FFFF);
		tick(2);
		chk("irq clear", 32'h0, irq);
		wr(`OFS_CFG_A, 32'h0);
		// 1000 hclk hold 30.88 t1 or 40.96 e1 reference periods
		for (int m = 0; m < 2; m++) begin
			wr(`OFS_CTRL, m);
			k = 31 + 10 * m;
			n = 0;
			for (int i = 0; i < 1000; i++) begin
				p = rco[0];
				tick(1);
				if (!p && rco[0]) n++;
			end
			chk("ref rises", k, (n == k - 1 || n == k) ? k : n);
		end
		wr(`OFS_CTRL, 32'h0);
		wr(`OFS_POWERDOWN, 32'h0001_FFFF);
		wr(`OFS_CFG_A, 32'h0000_0040);
		tick(3);
		chk("pd oe", 32'h0, rcoe);
		wr(`OFS_CFG_A, 32'h0);
		tick(3);
		chk("pd low oe", 32'h1_FFFF, rcoe);
		chk("pd low", 32'h0, rco);
		wr(`OFS_POWERDOWN, 32'h0);
		los_in <= 17'h0_0000;
	endtask
	task automatic t_edge();
		logic [16:0] lv;
		for (int e = 0; e < 2; e++) begin
			lv = {17{e[0]}};
			wr(`OFS_CFG_B, e ? 32'h0000_0011 : 32'h0000_0001);
			cdr_clk <= lv;
			cdr_pos <= 17'h0_0000;
			tick(5);
			cdr_clk <= ~lv;
			tick(5);
			cdr_clk <= lv;
			tick(5);
			cdr_pos <= 17'h1_FFFF;
			tick(5);
			chk("data held", 32'h0, rdp);
			chk("neg held", 32'h1_FFFF, rx_data_single_rail);
			cdr_clk <= ~lv;
			tick(5);
			chk("data on edge", 32'h1_FFFF, rdp);
			chk("neg on edge", 32'h0, rx_data_single_rail);
		end
		// clock enable low must freeze the pin path
		ce <= 1'b0;
		cdr_clk <= 17'h1_FFFF;
		tick(5);
		chk("frozen", 32'h0, rco);
		ce <= 1'b1;
		tick(5);
		chk("thawed", 32'h1_FFFF, rco);
	endtask
	initial begin
		#1_000_000;
		failures++;
		final_report();
	end
	initial begin
		tick(10);
		hresetn <= 1'b1;
		tick(1);
		t_reset();
		t_serial();
		t_slow();
		t_pin();
		t_edge();
		final_report();
	end
endmodule
`default_nettype wire
